// File: hw/frtc_consts.svh
// Constants for the free-running 16-bit timer counter
`ifndef FRTC_CONSTS_SVH
`define FRTC_CONSTS_SVH
`define FRTC_COUNT_RESET   16'hFFFC
`define FRTC_COUNT_MAX     16'hFFFF
`define FRTC_CC_DIV4       2'h0
`define FRTC_CC_DIV2       2'h1
`define FRTC_CC_DIV8       2'h2
`define FRTC_CC_EXT        2'h3
`define FRTC_PRESC_W       3
`endif

// File: hw/frtc_pkg.sv
// Types for the free-running 16-bit timer counter
package frtc_pkg;
    typedef enum logic [1:0] {
        FRTC_ACC_NONE,
        FRTC_ACC_MAIN,
        FRTC_ACC_ALT
    } frtc_view_t;
endpackage

// File: hw/frtc_timer.sv
// Free-running 16-bit timer counter core with byte read views
`include "frtc_consts.svh"

module frtc_timer
    import frtc_pkg::*;
#(
    parameter bit EXT_PIN_BONDED = 1'b1
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Configuration
    input  wire logic [1:0] clock_select_field,
    input  wire logic       ext_edge_select,
    input  wire logic       overflow_irq_enable,
    input  wire logic       cpu_irq_mask,
    // Power modes
    input  wire logic       wait_mode,
    input  wire logic       halt_mode,
    // External clock pin
    input  wire logic       ext_count_clock_pin,
    // Byte accesses, one-cycle strobes
    input  wire logic       rd_count_high_byte,
    input  wire logic       rd_count_low_byte,
    input  wire logic       rd_alt_count_high_byte,
    input  wire logic       rd_alt_count_low_byte,
    input  wire logic       wr_count_low_byte,
    input  wire logic       wr_alt_count_low_byte,
    input  wire logic       rd_timer_status_reg,
    // Read data and status
    output logic      [7:0] rd_data,
    output logic            overflow_flag,
    output logic            timer_irq,
    output logic     [15:0] count_value
);

    // Counter side, falling edge
    logic [15:0]               count_q;
    logic [`FRTC_PRESC_W-1:0]  presc_q;
    logic                      wrap_q;
    logic                      count_run;
    logic                      count_at_max;
    logic                      low_write;
    logic                      tick;
    logic                      div2_tick;
    logic                      div4_tick;
    logic                      div8_tick;

    // External pin path
    logic                      ext_pin;
    logic                      ext_s1_q;
    logic                      ext_s2_q;
    logic                      ext_s3_q;
    logic [1:0]                ext_prime_q;
    logic                      ext_primed;
    logic                      ext_rise;
    logic                      ext_fall;
    logic                      ext_edge;

    // Access side, rising edge
    logic [7:0]                low_buf_q;
    logic                      buf_valid_q;
    logic                      buf_capture;
    logic                      buf_release;
    logic                      flag_armed_q;
    logic                      flag_arm;
    logic                      flag_set;
    logic                      low_read;
    logic                      hi_read;
    logic                      main_low_access;
    logic                      clear_flag;
    logic                      irq_request;
    logic [7:0]                live_low;
    logic [7:0]                read_low;
    logic [7:0]                read_high;
    logic [7:0]                status_byte;
    logic [7:0]                rd_byte;
    frtc_view_t                view;

    // Strobe decode
    assign low_write       = wr_count_low_byte | wr_alt_count_low_byte;
    assign low_read        = rd_count_low_byte | rd_alt_count_low_byte;
    assign hi_read         = rd_count_high_byte | rd_alt_count_high_byte;
    assign main_low_access = rd_count_low_byte | wr_count_low_byte;
    assign count_run       = ~halt_mode;
    assign count_at_max    = (count_q == `FRTC_COUNT_MAX);

    // Unbonded pin reads as one
    assign ext_pin = EXT_PIN_BONDED ? ext_count_clock_pin : 1'b1;

    // External pin synchroniser, two stages
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
        end else begin
            ext_s1_q <= ext_pin;
            ext_s2_q <= ext_s1_q;
        end
    end

    // Edge stage
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            ext_s3_q <= 1'b1;
        end else begin
            ext_s3_q <= ext_s2_q;
        end
    end

    // Edges ignored until the chain holds real pin samples
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            ext_prime_q <= 2'h0;
        end else if (!ext_primed) begin
            ext_prime_q <= ext_prime_q + 2'h1;
        end
    end

    assign ext_primed = (ext_prime_q == 2'h3);
    assign ext_rise   = ext_primed & ext_s2_q & ~ext_s3_q;
    assign ext_fall   = ext_primed & ~ext_s2_q & ext_s3_q;

    // Rising when select set, falling otherwise
    assign ext_edge = ext_edge_select ? ext_rise : ext_fall;

    // Prescaler taps
    assign div2_tick = presc_q[0];
    assign div4_tick = &presc_q[1:0];
    assign div8_tick = &presc_q;

    // Tick selection from the clock field
    always_comb begin
        case (clock_select_field)
            `FRTC_CC_DIV2: tick = div2_tick;
            `FRTC_CC_DIV4: tick = div4_tick;
            `FRTC_CC_DIV8: tick = div8_tick;
            default:       tick = ext_edge;
        endcase
    end

    // Prescaler, frozen in halt, not in wait
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            presc_q <= '0;
        end else if (low_write) begin
            presc_q <= '0;
        end else if (count_run) begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // Counter
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            count_q <= `FRTC_COUNT_RESET;
        end else if (low_write) begin
            count_q <= `FRTC_COUNT_RESET;
        end else if (tick && count_run) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Rollover pulse, one full cycle wide
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            wrap_q <= 1'b0;
        end else begin
            wrap_q <= tick & count_run & ~low_write & count_at_max;
        end
    end

    // Two-byte read sequence control
    assign buf_release = low_read;
    assign buf_capture = hi_read & ~buf_valid_q & ~low_read;

    // Buffer held flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_valid_q <= 1'b0;
        end else if (buf_release) begin
            buf_valid_q <= 1'b0;
        end else if (buf_capture) begin
            buf_valid_q <= 1'b1;
        end
    end

    // Buffered low byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_buf_q <= 8'h00;
        end else if (buf_capture) begin
            low_buf_q <= count_q[7:0];
        end
    end

    // View named by the read strobe
    always_comb begin
        view = FRTC_ACC_NONE;
        if (rd_count_high_byte || rd_count_low_byte) begin
            view = FRTC_ACC_MAIN;
        end else if (rd_alt_count_high_byte || rd_alt_count_low_byte) begin
            view = FRTC_ACC_ALT;
        end
    end

    // Byte sources for the read port
    assign live_low    = count_q[7:0];
    assign read_high   = count_q[15:8];
    assign read_low    = buf_valid_q ? low_buf_q : live_low;
    assign status_byte = {overflow_flag, 7'h00};

    // Read byte select
    always_comb begin
        rd_byte = 8'h00;
        if (rd_timer_status_reg) begin
            rd_byte = status_byte;
        end else if (view != FRTC_ACC_NONE && hi_read) begin
            rd_byte = read_high;
        end else if (view != FRTC_ACC_NONE) begin
            rd_byte = read_low;
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_byte;
        end
    end

    // Flag control, only the main low byte clears
    assign flag_set   = wrap_q;
    assign flag_arm   = rd_timer_status_reg & overflow_flag;
    assign clear_flag = flag_armed_q & main_low_access;

    // Overflow flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (flag_set) begin
            overflow_flag <= 1'b1;
        end else if (clear_flag) begin
            overflow_flag <= 1'b0;
        end
    end

    // Clear sequence armed by a status read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_armed_q <= 1'b0;
        end else if (flag_arm) begin
            flag_armed_q <= 1'b1;
        end else if (clear_flag) begin
            flag_armed_q <= 1'b0;
        end
    end

    // Pending until enabled and unmasked
    assign irq_request = overflow_flag & overflow_irq_enable & ~cpu_irq_mask;

    // Interrupt request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= irq_request;
        end
    end

    // Count output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_value <= `FRTC_COUNT_RESET;
        end else begin
            count_value <= count_q;
        end
    end

endmodule

// File: test/frtc_ext_src.sv
// External count clock source for the timer pin
module frtc_ext_src (
    input  wire logic clk,
    input  wire logic run,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial pin = 1'b0;
    // Toggles every five cycles, under a quarter rate
    always @(negedge clk) begin
        n = (n + 1) % 5;
        if (run && n == 0) begin
            pin <= ~pin;
        end
    end
endmodule

// File: test/frtc_monitor.sv
// Checker for the timer counter ports
module frtc_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        overflow_irq_enable,
    input wire logic        cpu_irq_mask,
    input wire logic        halt_mode,
    input wire logic        rd_count_low_byte,
    input wire logic        rd_alt_count_low_byte,
    input wire logic        wr_count_low_byte,
    input wire logic        wr_alt_count_low_byte,
    input wire logic        rd_timer_status_reg,
    input wire logic [7:0]  rd_data,
    input wire logic        overflow_flag,
    input wire logic        timer_irq,
    input wire logic [15:0] count_value
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_arm; rd_timer_status_reg && overflow_flag; endsequence
    sequence s_low; rd_count_low_byte || wr_count_low_byte; endsequence
    AST_WR: assert property ((wr_count_low_byte || wr_alt_count_low_byte)
        |-> ##[1:2] count_value == 16'hFFFC) else $error("count not forced");
    AST_OVF: assert property (($past(count_value) == 16'hFFFF && count_value == 0)
        |-> ##[0:1] overflow_flag) else $error("flag not set");
    AST_HALT: assert property (halt_mode [*3] |-> $stable(count_value))
        else $error("count moved in halt");
    AST_STAT: assert property (rd_timer_status_reg
        |=> rd_data == {$past(overflow_flag), 7'h00}) else $error("bad status");
    AST_ALT: assert property (rd_alt_count_low_byte && overflow_flag |=> overflow_flag)
        else $error("alt read cleared flag");
    AST_CLR: assert property (s_arm ##[1:2] s_low |=> !overflow_flag)
        else $error("flag not cleared");
    AST_IRQ: assert property ((overflow_flag && overflow_irq_enable && !cpu_irq_mask) [*2]
        |-> timer_irq) else $error("irq missing");
    AST_NOIRQ: assert property ((!overflow_flag || !overflow_irq_enable || cpu_irq_mask) [*2]
        |-> !timer_irq) else $error("irq unexpected");
endmodule
bind frtc_timer frtc_monitor u_mon (.*);

// File: test/frtc_timer_tb.sv
// Bench for the timer counter core
module frtc_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, edge_sel = 1'b0, irq_en = 1'b0, irq_mask = 1'b1;
    logic wait_m = 1'b0, halt_m = 1'b0, ext_run = 1'b0, ext_pin, flag, irq;
    logic [1:0]  sel = 2'h0;
    logic [6:0]  acc = 7'h00;
    logic [7:0]  rd_data;
    logic [15:0] cnt, snap;
    int          num_errors = 0, checks_done = 0, n;
    always #25 clk = ~clk;
    frtc_ext_src src (.clk(clk), .run(ext_run), .pin(ext_pin));
    frtc_timer dut (.clk(clk), .rst_n(rst_n), .clock_select_field(sel),
        .ext_edge_select(edge_sel), .overflow_irq_enable(irq_en), .cpu_irq_mask(irq_mask),
        .wait_mode(wait_m), .halt_mode(halt_m), .ext_count_clock_pin(ext_pin),
        .rd_count_high_byte(acc[0]), .rd_count_low_byte(acc[1]),
        .rd_alt_count_high_byte(acc[2]), .rd_alt_count_low_byte(acc[3]),
        .wr_count_low_byte(acc[4]), .wr_alt_count_low_byte(acc[5]),
        .rd_timer_status_reg(acc[6]), .rd_data(rd_data), .overflow_flag(flag),
        .timer_irq(irq), .count_value(cnt));
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic strobe(input logic [6:0] s);
        @(negedge clk) acc <= s;
        @(posedge clk) snap = cnt;
        @(negedge clk) acc <= 7'h00;
    endtask
    task automatic wait_change();
        logic [15:0] v;
        v = cnt;
        n = 0;
        while (cnt === v && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic t_rate();
        int tab[5][3] = '{'{0, 0, 4}, '{1, 0, 2}, '{2, 1, 8}, '{3, 1, 10}, '{3, 0, 10}};
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            sel <= 2'(tab[i][0]);
            edge_sel <= tab[i][1][0];
            ext_run <= (tab[i][0] == 3);
            wait_m <= i[0];
            strobe(7'h20);
            wait_change();
            wait_change();
            wait_change();
            chk(16'(n), 16'(tab[i][2]));
        end
        ext_run = 1'b0;
        $display("rate test end");
    endtask
    task automatic t_ovf();
        sel = 2'h1;
        irq_en = 1'b1;
        strobe(7'h10);
        repeat (12) @(negedge clk);
        chk(flag, 1);
        chk(irq, 0);
        irq_mask = 1'b0;
        repeat (2) @(negedge clk);
        chk(irq, 1);
        strobe(7'h08);
        chk(flag, 1);
        strobe(7'h40);
        chk(rd_data, 16'h0080);
        strobe(7'h02);
        chk(flag, 0);
        @(negedge clk);
        chk(irq, 0);
        $display("overflow test end");
    endtask
    task automatic t_buf();
        logic [15:0] c;
        sel <= 2'h2;
        strobe(7'h04);
        c = snap;
        chk(rd_data, 16'(snap[15:8]));
        repeat (40) @(negedge clk);
        strobe(7'h01);
        repeat (40) @(negedge clk);
        strobe(7'h08);
        chk(16'(8'(rd_data - c[7:0]) <= 8'h01), 16'h0001);
        repeat (40) @(negedge clk);
        strobe(7'h02);
        chk(16'(8'(rd_data - snap[7:0]) <= 8'h01), 16'h0001);
        $display("buffer test end");
    endtask
    task automatic t_halt();
        logic [15:0] c;
        halt_m <= 1'b1;
        repeat (3) @(negedge clk);
        c = cnt;
        repeat (30) @(negedge clk);
        chk(cnt, c);
        halt_m <= 1'b0;
        wait_change();
        chk(cnt, c + 16'h0001);
        @(negedge clk) halt_m <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        halt_m <= 1'b0;
        chk(cnt, 16'hFFFC);
        rst_n <= 1'b1;
        $display("halt test end");
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n <= 1'b1;
        chk(cnt, 16'hFFFC);
        chk({flag, irq, rd_data}, 16'h0000);
        t_rate();
        t_ovf();
        t_buf();
        t_halt();
        print_verdict();
    end
endmodule
